// file: design/sch_host_ctl.sv
// Host control and status block of a serial adapter card.
// Assumes I/O strobes are synchronous one-cycle requests; memory requests are held until acknowledged.
`timescale 1ns/1ps
module sch_host_ctl
#(
  parameter logic [15:0] SEC_WORD = sch_pkg::SEC_WORD_DEF,
  parameter int CHARGE_WRITES = sch_pkg::CHARGE_WRITES_DEF
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Host I/O register port
  input wire logic i_io_cs,
  input wire logic i_io_we,
  input wire logic [2:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_ack,
  // Host memory window port
  input wire logic i_mem_req,
  input wire logic i_win_high,
  input wire logic [sch_pkg::WIN_AW-1:0] i_mem_addr,
  output logic o_mem_ack,
  output logic o_mem_refused,
  output logic o_ram_sel,
  output logic o_ctl_sel,
  output logic [sch_pkg::WIN_AW-1:0] o_ram_addr,
  // Controller DMA port
  input wire logic i_dma_req,
  output logic o_dma_gnt,
  // Controller side
  input wire logic i_ctl_irq_n,
  output logic o_ctl_clk_en,
  output logic o_ctl_reset,
  output logic o_host_irq,
  // Line transceiver
  output logic [3:0] o_line_mode,
  output logic o_local_loop,
  output logic o_remote_loop
);
  import sch_pkg::*;

  // ************************************************
  // Parameter checks
  // ************************************************
  if (CHARGE_WRITES < 1 || CHARGE_WRITES > 255) begin : g_chk
    $error("CHARGE_WRITES out of range");
  end

  // ************************************************
  // Control state
  // ************************************************
  logic host_window_gate; // Window access allowed
  logic ram_or_controller_select; // 1 RAM, 0 controller
  logic [3:0] ram_page_select; // Visible 16K page
  logic lin_layout; // 1 linear, 0 paged
  logic interrupt_gate; // Host interrupt enabled
  logic [3:0] line_mode_select; // Transceiver mode
  logic local_loop_drive; // Local loopback
  logic remote_loop_drive; // Remote loopback
  logic [15:0] osc_acc; // Fractional rate accumulator

  sch_rst_if rif (); // Link to reset sequencer

  // Decoded strobes
  logic io_wr; // Register write this cycle
  logic io_rd; // Register read this cycle
  logic mem_take; // Host window request taken
  assign io_wr = i_io_cs && i_io_we;
  assign io_rd = i_io_cs && !i_io_we;
  // DMA has priority; host must hold its request
  assign mem_take = i_mem_req && !i_dma_req;

  // Address inside the controller's register span
  function automatic logic in_ctl_span(
    input logic [WIN_AW-1:0] a);
    in_ctl_span = (a[WIN_AW-1:CTL_AW] == '0);
  endfunction

  // Write strobe for one register offset
  function automatic logic wr_hit(input logic [2:0] ofs);
    wr_hit = io_wr && (i_io_addr == ofs);
  endfunction

  // ************************************************
  // Window access register
  // ************************************************
  // Bits 5 and 4 are not stored at all
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      host_window_gate <= 1'b0;
      ram_or_controller_select <= 1'b0;
      ram_page_select <= RST_PAGE;
    end else if (wr_hit(OFS_WIN)) begin
      host_window_gate <= i_io_wdata[BIT_GATE];
      ram_or_controller_select <= i_io_wdata[BIT_RAMSEL];
      ram_page_select <= i_io_wdata[3:0];
    end
  end

  // ************************************************
  // Layout select register
  // ************************************************
  // Only the top bit is stored
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      lin_layout <= 1'b0;
    end else if (wr_hit(OFS_LAYOUT)) begin
      lin_layout <= i_io_wdata[BIT_LIN];
    end
  end

  // ************************************************
  // Interrupt enable register
  // ************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      interrupt_gate <= 1'b0;
    end else if (wr_hit(OFS_IRQ)) begin
      interrupt_gate <= i_io_wdata[BIT_IRQ];
    end
  end

  // ************************************************
  // Line mode and loopback register
  // ************************************************
  // Modes marked unsupported are passed through; the
  // transceiver decides what they do
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      line_mode_select <= RST_MODE;
      local_loop_drive <= 1'b0;
      remote_loop_drive <= 1'b0;
    end else if (wr_hit(OFS_LINE)) begin
      line_mode_select <= i_io_wdata[3:0];
      local_loop_drive <= i_io_wdata[BIT_LL];
      remote_loop_drive <= i_io_wdata[BIT_RL];
    end
  end

  // Any write to the reset register, value ignored
  assign rif.kick = wr_hit(OFS_RST);

  // ************************************************
  // Reset charge sequencer
  // ************************************************
  sch_reset_charge #(
    .CHARGE_WRITES(CHARGE_WRITES),
    .HOLD_CYC(RST_HOLD_CYC)
  ) u_chg (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .rif(rif.chg)
  );

  // ************************************************
  // Register read path
  // ************************************************
  // Data is held between reads so the host may sample late
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_io_rdata <= 8'h00;
      o_io_ack <= 1'b0;
    end else begin
      o_io_ack <= i_io_cs;
      if (io_rd) begin
        if (i_io_addr == OFS_WIN) begin
          o_io_rdata <= FIX_WIN | {host_window_gate,
            ram_or_controller_select, 2'b00,
            ram_page_select};
        end else if (i_io_addr == OFS_ZERO) begin
          o_io_rdata <= 8'h00;
        end else if (i_io_addr == OFS_LAYOUT) begin
          o_io_rdata <= FIX_LAYOUT | {lin_layout, 7'h00};
        end else if (i_io_addr == OFS_RST) begin
          // Pending is active low; status reads 0 in reset
          o_io_rdata <= FIX_RST | {2'b00, i_ctl_irq_n,
            !rif.active, 4'h0};
        end else if (i_io_addr == OFS_IRQ) begin
          o_io_rdata <= {1'b0, interrupt_gate, 6'h00};
        end else if (i_io_addr == OFS_LINE) begin
          o_io_rdata <= {local_loop_drive, remote_loop_drive,
            2'b00, line_mode_select};
        end else if (i_io_addr == OFS_SEC_LO) begin
          o_io_rdata <= SEC_WORD[7:0];
        end else begin
          o_io_rdata <= SEC_WORD[15:8];
        end
      end
    end
  end

  // ************************************************
  // Memory window steering
  // ************************************************
  // Linear layout in a low window is a host error; refused
  // rather than aliased so it shows up in testing
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_mem_ack <= 1'b0;
      o_mem_refused <= 1'b0;
      o_ram_sel <= 1'b0;
      o_ctl_sel <= 1'b0;
      o_ram_addr <= '0;
      o_dma_gnt <= 1'b0;
    end else begin
      o_dma_gnt <= i_dma_req;
      o_mem_ack <= mem_take;
      o_ram_sel <= 1'b0;
      o_ctl_sel <= 1'b0;
      o_mem_refused <= 1'b0;
      if (mem_take) begin
        if (!host_window_gate) begin
          o_mem_refused <= 1'b1;
        end else if (lin_layout && !i_win_high) begin
          o_mem_refused <= 1'b1;
        end else if (!ram_or_controller_select &&
            in_ctl_span(i_mem_addr)) begin
          o_ctl_sel <= 1'b1;
          o_ram_addr <= i_mem_addr;
        end else if (lin_layout) begin
          o_ram_sel <= 1'b1;
          o_ram_addr <= i_mem_addr;
        end else begin
          o_ram_sel <= 1'b1;
          o_ram_addr <= {ram_page_select,
            i_mem_addr[PAGE_AW-1:0]};
        end
      end
    end
  end

  // ************************************************
  // Controller clock enable
  // ************************************************
  // No integer divider gives 20 MHz from 25 MHz, so a
  // fractional accumulator fires four cycles out of five
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      // Start one step short of a fire so that the first
      // four enables after reset follow the steady pattern
      osc_acc <= 16'(OSC_KHZ);
      o_ctl_clk_en <= 1'b0;
    end else if (osc_acc + 16'(OSC_KHZ) >= 16'(SYS_KHZ)) begin
      osc_acc <= osc_acc + 16'(OSC_KHZ) - 16'(SYS_KHZ);
      o_ctl_clk_en <= 1'b1;
    end else begin
      osc_acc <= osc_acc + 16'(OSC_KHZ);
      o_ctl_clk_en <= 1'b0;
    end
  end

  // ************************************************
  // Outputs to controller and transceiver
  // ************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ctl_reset <= 1'b0;
      o_host_irq <= 1'b0;
      o_line_mode <= RST_MODE;
      o_local_loop <= 1'b0;
      o_remote_loop <= 1'b0;
    end else begin
      o_ctl_reset <= rif.active;
      o_host_irq <= interrupt_gate && !i_ctl_irq_n;
      o_line_mode <= line_mode_select;
      o_local_loop <= local_loop_drive;
      o_remote_loop <= remote_loop_drive;
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_gate_blocks: assert property (
    mem_take && !host_window_gate |=>
    o_mem_refused && !o_ram_sel && !o_ctl_sel)
    else $error("window used while gate closed");
  a_ctl_span: assert property (
    mem_take && host_window_gate && !lin_layout &&
    !ram_or_controller_select && in_ctl_span(i_mem_addr)
    |=> o_ctl_sel && !o_ram_sel)
    else $error("controller span not steered");
  a_ram_span: assert property (
    mem_take && host_window_gate && ram_or_controller_select
    && (i_win_high || !lin_layout) |=> o_ram_sel && !o_ctl_sel)
    else $error("RAM select not honoured");
  a_page_addr: assert property (
    mem_take && host_window_gate && !lin_layout &&
    ram_or_controller_select |=> o_ram_addr ==
    {$past(ram_page_select), $past(i_mem_addr[PAGE_AW-1:0])})
    else $error("paged address wrong");
  a_linear_low: assert property (
    mem_take && host_window_gate && lin_layout && !i_win_high
    |=> o_mem_refused)
    else $error("linear low window accepted");
  a_linear_addr: assert property (
    mem_take && host_window_gate && lin_layout && i_win_high
    && ram_or_controller_select |=> o_ram_addr == $past(i_mem_addr))
    else $error("linear address wrong");
  a_dma_first: assert property (
    i_dma_req |=> o_dma_gnt && !o_mem_ack)
    else $error("DMA not given priority");
  a_pend_level: assert property (
    io_rd && i_io_addr == OFS_RST |=>
    o_io_rdata[BIT_PEND] == $past(i_ctl_irq_n) &&
    o_io_rdata[BIT_RSTAT] == !$past(rif.active))
    else $error("reset register status wrong");
  a_zero_reg: assert property (
    io_rd && i_io_addr == OFS_ZERO |=> o_io_rdata == 8'h00)
    else $error("unused register not zero");
  a_sec_word: assert property (
    io_rd && i_io_addr[2:1] == 2'b11 |=> o_io_rdata ==
    ($past(i_io_addr[0]) ? SEC_WORD[15:8] : SEC_WORD[7:0]))
    else $error("security word wrong");
  a_line_out: assert property (
    wr_hit(OFS_LINE) |=> ##1 o_line_mode == $past(i_io_wdata[3:0], 2)
    && o_local_loop == $past(i_io_wdata[BIT_LL], 2)
    && o_remote_loop == $past(i_io_wdata[BIT_RL], 2))
    else $error("line mode not driven");
  a_clk_rate: assert property (
    !o_ctl_clk_en |=> o_ctl_clk_en [*4])
    else $error("controller clock rate wrong");
  a_layout_rst: assert property (
    $rose(lin_layout) |-> $past(wr_hit(OFS_LAYOUT)))
    else $error("layout changed without write");

  c_ctl_access: cover property (mem_take ##1 o_ctl_sel);
  c_page_access: cover property (
    mem_take && !lin_layout ##1 o_ram_sel);
  c_board_reset: cover property ($rose(o_ctl_reset));
  c_irq: cover property ($rose(o_host_irq));
endmodule

// file: design/sch_pkg.sv
// Package of constants and types for the serial card host control block.
// Assumes a single 25 MHz system clock shared by every file of the block.
package sch_pkg;
  // ************************************************
  // Clock and timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYS_KHZ = 25000; // System clock rate
  localparam int OSC_KHZ = 20000; // Serial controller clock rate
  // Hold time of the on-board reset once charged
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CYC =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Writes needed to discharge the reset capacitor
  localparam int CHARGE_WRITES_DEF = 4;

  // ************************************************
  // I/O register offsets
  // ************************************************
  localparam logic [2:0] OFS_WIN = 3'h0; // window_access_and_page
  localparam logic [2:0] OFS_ZERO = 3'h1; // unused_zero
  localparam logic [2:0] OFS_LAYOUT = 3'h2; // window_layout_select
  localparam logic [2:0] OFS_RST = 3'h3; // board_reset_and_status
  localparam logic [2:0] OFS_IRQ = 3'h4; // interrupt_enable
  localparam logic [2:0] OFS_LINE = 3'h5; // line_mode_and_loopback
  localparam logic [2:0] OFS_SEC_LO = 3'h6; // security_word_low
  localparam logic [2:0] OFS_SEC_HI = 3'h7; // security_word_high

  // ************************************************
  // Field positions
  // ************************************************
  localparam int BIT_GATE = 7; // host_window_gate
  localparam int BIT_RAMSEL = 6; // ram_or_controller_select
  localparam int BIT_LIN = 7; // Linear / paged layout
  localparam int BIT_PEND = 5; // controller_irq_pending_n
  localparam int BIT_RSTAT = 4; // onboard_reset_status
  localparam int BIT_IRQ = 6; // interrupt_gate
  localparam int BIT_LL = 7; // local_loop_drive
  localparam int BIT_RL = 6; // remote_loop_drive

  // ************************************************
  // Constant read bits and reset values
  // ************************************************
  localparam logic [7:0] FIX_WIN = 8'h10;
  localparam logic [7:0] FIX_LAYOUT = 8'h20;
  localparam logic [7:0] FIX_RST = 8'h08;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [15:0] SEC_WORD_DEF = 16'hFFFF;

  // ************************************************
  // Memory window geometry
  // ************************************************
  localparam int WIN_AW = 18; // 256K window
  localparam int PAGE_AW = 14; // 16K page
  localparam int CTL_AW = 8; // 256 byte controller span

  // Transfer modes of the controller's DMA engine
  typedef enum {
    DMA_SINGLE, DMA_PIPELINED, DMA_ARRAY, DMA_LINKED
  } sch_dma_mode_t;

  // States of the reset charge sequencer
  typedef enum {ST_CHARGE, ST_HOLD} sch_chg_state_t;
endpackage

// file: design/sch_rst_if.sv
// Interface between register decode and the reset charge sequencer.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
interface sch_rst_if;
  logic kick; // One-cycle pulse per write to the reset register
  logic active; // On-board reset currently asserted
  modport ctl (output kick, input active);
  modport chg (input kick, output active);
endinterface

// file: design/sch_reset_charge.sv
// Reset charge sequencer: writes discharge, then a timed reset pulse.
// Assumes kick pulses are single cycles from the register decode.
`timescale 1ns/1ps
module sch_reset_charge
  import sch_pkg::*;
#(
  parameter int CHARGE_WRITES = sch_pkg::CHARGE_WRITES_DEF,
  parameter int HOLD_CYC = sch_pkg::RST_HOLD_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Link to register decode
  sch_rst_if.chg rif
);
  // ************************************************
  // Parameter checks
  // ************************************************
  if (CHARGE_WRITES < 1 || CHARGE_WRITES > 255) begin : g_chk_w
    $error("CHARGE_WRITES out of range");
  end
  if (HOLD_CYC < 1 || HOLD_CYC > 65535) begin : g_chk_h
    $error("HOLD_CYC out of range");
  end

  sch_chg_state_t state; // Charging or holding reset
  logic [7:0] charge; // Writes seen so far
  logic [15:0] hold; // Cycles left in reset

  // ************************************************
  // Sequencer
  // ************************************************
  // Writes during the hold are ignored; the capacitor is flat
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= ST_CHARGE;
      charge <= 8'h00;
      hold <= 16'h0000;
      rif.active <= 1'b0;
    end else begin
      case (state)
        ST_CHARGE: begin
          if (rif.kick) begin
            if (charge == 8'(CHARGE_WRITES - 1)) begin
              state <= ST_HOLD;
              hold <= 16'(HOLD_CYC - 1);
              rif.active <= 1'b1;
              charge <= 8'h00;
            end else begin
              charge <= charge + 8'h01;
            end
          end
        end
        ST_HOLD: begin
          if (hold == 16'h0000) begin
            state <= ST_CHARGE;
            rif.active <= 1'b0;
          end else begin
            hold <= hold - 16'h0001;
          end
        end
        default: state <= ST_CHARGE;
      endcase
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_charge_fires: assert property (
    state == ST_CHARGE && rif.kick &&
    charge == 8'(CHARGE_WRITES - 1) |=> rif.active)
    else $error("reset not entered after last write");
  a_charge_early: assert property (
    state == ST_CHARGE && rif.kick &&
    charge < 8'(CHARGE_WRITES - 1) |=> !rif.active)
    else $error("reset entered too early");
  a_hold_ends: assert property (
    state == ST_HOLD && hold == 16'h0000 |=> !rif.active)
    else $error("reset held too long");
  c_reset_cycle: cover property (
    $rose(rif.active) ##[1:1000] $fell(rif.active));
endmodule

// file: dv/sch_ctl_model.sv
// Behavioural model of the on-board serial controller's host-facing pins.
// Assumes the bench commands its interrupt and DMA demand levels.
`timescale 1ns/1ps
module sch_ctl_model (
  // Clock
  input wire logic i_sys_clk,
  // Commands from the bench
  input wire logic i_irq_on,
  input wire logic i_dma_on,
  // Pins toward the block
  input wire logic i_clk_en,
  output logic o_irq_n,
  output logic o_dma_req,
  output logic [15:0] o_tick_cnt
);
  // Pins move on the falling edge, clear of the sampling edge
  always @(negedge i_sys_clk) begin
    o_irq_n <= !i_irq_on;
    o_dma_req <= i_dma_on;
  end
  // Counts controller clock ticks so the bench can check the rate
  initial o_tick_cnt = 16'h0000;
  always @(posedge i_sys_clk) begin
    if (i_clk_en === 1'b1) begin
      o_tick_cnt <= o_tick_cnt + 16'h0001;
    end
  end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the host control block.
// Assumes the controller model drives the interrupt and DMA lines.
`timescale 1ns/1ps
module tb_top;
  import sch_pkg::*;
  logic i_sys_clk, i_rst, cs, we, mreq, whigh, irq_on, dma_on;
  logic [2:0] a;
  logic [7:0] wd, q;
  logic [17:0] ma;
  logic irq_n, dreq, io_ack, m_ack, m_ref, r_sel, c_sel, gnt, cen, crst;
  logic hirq, ll, rl;
  logic [7:0] rdata;
  logic [3:0] lmode;
  logic [17:0] raddr;
  logic [15:0] ticks, t0;
  int fails = 0, checks = 0, n;
  // Write/read rows: offset, data written, value read back
  logic [2:0] ra [11] = '{0, 1, 2, 4, 5, 6, 7, 5, 0, 2, 4};
  logic [7:0] rw [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00,
    8'h00, 8'h3A, 8'h25, 8'h7F, 8'hBF};
  logic [7:0] re [11] = '{8'hDF, 8'h00, 8'hA0, 8'h40, 8'hCF, 8'hFF,
    8'hFF, 8'h0A, 8'h15, 8'h20, 8'h00};
  logic [7:0] rv [8] = '{8'h10, 8'h00, 8'h20, 8'h38, 8'h00, 8'h00,
    8'hFF, 8'hFF};

  sch_host_ctl i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_io_cs(cs),
    .i_io_we(we), .i_io_addr(a), .i_io_wdata(wd), .o_io_rdata(rdata),
    .o_io_ack(io_ack), .i_mem_req(mreq), .i_win_high(whigh),
    .i_mem_addr(ma), .o_mem_ack(m_ack), .o_mem_refused(m_ref),
    .o_ram_sel(r_sel), .o_ctl_sel(c_sel), .o_ram_addr(raddr),
    .i_dma_req(dreq), .o_dma_gnt(gnt), .i_ctl_irq_n(irq_n),
    .o_ctl_clk_en(cen), .o_ctl_reset(crst), .o_host_irq(hirq),
    .o_line_mode(lmode), .o_local_loop(ll), .o_remote_loop(rl));
  sch_ctl_model i_ctl (.i_sys_clk(i_sys_clk), .i_irq_on(irq_on),
    .i_dma_on(dma_on), .i_clk_en(cen), .o_irq_n(irq_n),
    .o_dma_req(dreq), .o_tick_cnt(ticks));

  // ****************************************
  // Clock, checking and bus tasks
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One register access; the answer is sampled half a cycle after the take
  task automatic io(input logic w, input logic [2:0] ad,
      input logic [7:0] d);
    @(negedge i_sys_clk);
    cs = 1'b1;
    we = w;
    a = ad;
    wd = d;
    @(negedge i_sys_clk);
    cs = 1'b0;
    chk(io_ack, 1'b1);
    q = rdata;
  endtask
  // Window access held until acknowledged, bounded wait
  task automatic mem(input logic [17:0] ad, input logic [2:0] e,
      input logic [17:0] ea);
    @(negedge i_sys_clk);
    mreq = 1'b1;
    ma = ad;
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
      if (n > 20) begin
        fails++;
        report_and_stop();
      end
    end while (m_ack !== 1'b1);
    mreq = 1'b0;
    chk({r_sel, c_sel, m_ref}, e);
    if (!e[0]) chk(raddr, ea);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_rst, cs, we, mreq, whigh, irq_on, dma_on} = 7'h40;
    {a, wd, ma} = '0;
    repeat (16) @(negedge i_sys_clk);
    i_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      io(1'b0, i[2:0], 8'h00);
      chk(q, rv[i]);
    end
    for (int i = 0; i < 11; i++) begin
      io(1'b1, ra[i], rw[i]);
      io(1'b0, ra[i], 8'h00);
      chk(q, re[i]);
    end
    chk({ll, rl, lmode}, 6'h0A);
    // Both loopback pins high, mode 5
    io(1'b1, OFS_LINE, 8'hC5);
    @(negedge i_sys_clk);
    chk({ll, rl, lmode}, 6'h35);
    // Gate closed refuses an access; with it open, controller span, paged and linear steering
    mem(18'h00010, 3'h1, 18'h0);
    io(1'b1, OFS_WIN, 8'h85);
    mem(18'h00040, 3'h2, 18'h00040);
    mem(18'h00100, 3'h4, 18'h14100);
    io(1'b1, OFS_WIN, 8'hC5);
    mem(18'h00040, 3'h4, 18'h14040);
    io(1'b1, OFS_LAYOUT, 8'h80);
    mem(18'h23456, 3'h1, 18'h0);
    whigh = 1'b1;
    mem(18'h23456, 3'h4, 18'h23456);
    // DMA holds the RAM: host waits, then is served
    dma_on = 1'b1;
    // Let the demand reach the pin before the host asks
    @(negedge i_sys_clk);
    mreq = 1'b1;
    ma = 18'h00007;
    repeat (4) @(negedge i_sys_clk);
    chk({m_ack, gnt}, 2'h1);
    dma_on = 1'b0;
    mreq = 1'b0;
    mem(18'h00007, 3'h4, 18'h00007);
    // Controller rate: 4 ticks in every 5 cycles
    t0 = ticks;
    repeat (50) @(negedge i_sys_clk);
    chk(ticks - t0, 18'd40);
    // Interrupt gating and pending status
    irq_on = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk(hirq, 1'b0);
    io(1'b1, OFS_IRQ, 8'h40);
    @(negedge i_sys_clk);
    chk(hirq, 1'b1);
    io(1'b0, OFS_RST, 8'h00);
    chk(q, 8'h18);
    irq_on = 1'b0;
    // Reset charge: writes, then status low, then back high
    for (int i = 0; i < CHARGE_WRITES_DEF; i++) io(1'b1, OFS_RST, 8'h00);
    io(1'b0, OFS_RST, 8'h00);
    chk({q, crst}, 9'h051);
    n = 0;
    do begin
      io(1'b0, OFS_RST, 8'h00);
      n++;
      if (n > 40) begin
        fails++;
        report_and_stop();
      end
    end while (q[BIT_RSTAT] !== 1'b1);
    chk(n > 8, 1'b1);
    @(negedge i_sys_clk);
    chk({q, crst}, 9'h070);
    // Mid-run reset returns the control bits to zero
    i_rst = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'b0;
    io(1'b0, OFS_WIN, 8'h00);
    chk(q, FIX_WIN);
    io(1'b0, OFS_LAYOUT, 8'h00);
    chk(q, FIX_LAYOUT);
    report_and_stop();
  end
endmodule
